// ### pkg/psq_map.svh
`ifndef PSQ_MAP_SVH
`define PSQ_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define PSQ_CTRL_OFS 8'h00
`define PSQ_PERIOD_OFS 8'h04
`define PSQ_STATUS_OFS 8'h08
`define PSQ_LEVEL_OFS 8'h0C
// ==========================================================
// Field positions
`define PSQ_CTRL_ENABLE_BIT 0
`define PSQ_CTRL_RESTART_BIT 1
`define PSQ_ST_DRIVE_BIT 0
`define PSQ_ST_SYNC_BIT 1
`define PSQ_ST_SHUT_BIT 2
`define PSQ_ST_CHARGE_BIT 3
`define PSQ_ST_WIDTH_BIT 4
`define PSQ_ST_STATE_LSB 8
// ==========================================================
// Reset values
`define PSQ_ENABLE_RESET 1'h1
`define PSQ_PERIOD_RESET 10'h10B
// ==========================================================
// Timing
`define PSQ_CLK_PERIOD_NS 25
`define PSQ_DUTY_MAX_PCT 72
`define PSQ_PW_MIN_NS 25
`define PSQ_PW_MAX_NS 200
`define PSQ_PW_MIN_CYC ((`PSQ_PW_MIN_NS + `PSQ_CLK_PERIOD_NS - 1) / `PSQ_CLK_PERIOD_NS)
`define PSQ_PW_MAX_CYC (`PSQ_PW_MAX_NS / `PSQ_CLK_PERIOD_NS)
`define PSQ_SS_FULL 8'hFF
`define PSQ_SS_LOW 8'h33
`define PSQ_SS_CHARGE_DIV 8'h40
`define PSQ_SS_DISCHARGE_DIV 8'h5A
`endif

// ### pkg/psq_pkg.sv
package psq_pkg;
  `include "psq_map.svh"

  typedef logic [9:0] count_t;
  typedef logic [7:0] level_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_RAMP = 4'h2,
    ST_RUN = 4'h4,
    ST_SHUT = 4'h8
  } seq_state_e;

  // Largest on-time inside one oscillator period
  function automatic count_t max_on(input count_t period);
    logic [16:0] prod;
    prod = 17'(period) * 17'(`PSQ_DUTY_MAX_PCT);
    return count_t'(prod / 17'h064);
  endfunction : max_on

  // On-time allowed for a soft-start level
  function automatic count_t duty_limit(input count_t cap, input level_t ss);
    logic [17:0] prod;
    prod = 18'h0;
    if (ss > `PSQ_SS_LOW)
      prod = 18'(cap) * 18'(ss - `PSQ_SS_LOW);
    return count_t'(prod / 18'(`PSQ_SS_FULL - `PSQ_SS_LOW));
  endfunction : duty_limit
endpackage : psq_pkg

// ### rtl/startup_oscillator.sv
`timescale 1ns/10ps
module startup_oscillator
  import psq_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire count_t period_i,
  output logic cycle_start_o,
  output logic on_end_o,
  output count_t phase_o
);
  count_t phase;
  count_t next_phase;
  logic wrap;

  // ==========================================================
  // Period counter
  assign wrap = (phase >= period_i - 10'h001);
  assign next_phase = wrap ? 10'h000 : phase + 10'h001;

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      phase <= 10'h000;
    else if (ce_i)
      phase <= next_phase;
  end

  // ==========================================================
  // Cycle events, registered
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      cycle_start_o <= 1'b0;
      on_end_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cycle_start_o <= wrap;
      on_end_o <= (next_phase == max_on(period_i));
    end
  end

  assign phase_o = phase;
endmodule : startup_oscillator

// ### rtl/primary_side_pwm_sequencer.sv
// Notes on behaviour
// - Low overcurrent level ends pulse each cycle
// - High overcurrent level forces soft-start restart
// - Each current-limit termination charges delayed fault
// - Start pulse sets drive once synced, stop resets
// - Drive held low during shutdown
// - Oscillator caps duty at 72 percent always
// - Delayed fault sets the shutdown latch
// - Clamp released at pulse start; threshold ends pulse
// - Soft-start at power-up and after faults
// - Undervoltage, high current, restart bit, disable restart soft-start
// - Drive held low until soft-start discharged
// - Duty ramps from zero to cap
// - Two-sided command detection with deadband
// - First stop pulse resets drive, sets sync
// - Synced drive follows secondary; oscillator set blocked
// - Fault soft-start clears sync latch
// - Drive latch reset-dominant, set source gated
// - Drive reset is OR of nine sources
// - Lockout holds drive low, discharges soft-start node
// - Current-limit latch reset by oscillator each cycle
// - Overvoltage latches; undervoltage holds soft-start low
`timescale 1ns/10ps
module primary_side_pwm_sequencer
  import psq_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic cs_low_i,
  input wire logic cs_high_i,
  input wire logic pulse_command_start_i,
  input wire logic pulse_command_stop_i,
  input wire logic delayed_fault_input_i,
  input wire logic overvoltage_sense_i,
  input wire logic undervoltage_sense_i,
  input wire logic voltsecond_sense_i,
  output logic drive_o,
  output logic sync_o,
  output logic shutdown_o,
  output logic voltsecond_clamp_o,
  output logic delayed_fault_charge_o,
  output logic soft_start_discharge_o
);
  // ==========================================================
  // Declarations
  seq_state_e state;
  seq_state_e next_state;
  logic enable;
  logic restart_req;
  count_t period;
  level_t ss_level;
  logic [7:0] ss_tick;
  logic drive;
  logic next_drive;
  logic sync;
  logic shut_latch;
  logic charge_latch;
  logic width_err;
  logic start_q;
  logic stop_q;
  logic start_edge;
  logic stop_edge;
  logic [3:0] start_len;
  logic [3:0] stop_len;
  logic osc_start;
  logic osc_on_end;
  count_t phase;
  count_t cap;
  count_t limit;
  logic drive_en;
  logic fault_restart;
  logic shut_req;
  logic duty_end;
  logic drive_clr;
  logic drive_set;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  logic [31:0] rd_value;

  // ==========================================================
  // Startup oscillator
  startup_oscillator osc
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .period_i(period),
    .cycle_start_o(osc_start),
    .on_end_o(osc_on_end),
    .phase_o(phase)
  );

  // ==========================================================
  // Command edge detection
  // Comparators already give the deadband; here only edges
  assign start_edge = pulse_command_start_i & ~start_q;
  assign stop_edge = pulse_command_stop_i & ~stop_q;

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else if (ce_i)
    begin
      start_q <= pulse_command_start_i;
      stop_q <= pulse_command_stop_i;
    end
  end

  // Pulse length watch; a stuck command is flagged, not obeyed twice
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      start_len <= 4'h0;
      stop_len <= 4'h0;
    end
    else if (ce_i)
    begin
      start_len <= !pulse_command_start_i ? 4'h0 :
                   (start_len == 4'hF) ? start_len : start_len + 4'h1;
      stop_len <= !pulse_command_stop_i ? 4'h0 :
                  (stop_len == 4'hF) ? stop_len : stop_len + 4'h1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      width_err <= 1'b0;
    else if (ce_i)
    begin
      if (start_len > 4'(`PSQ_PW_MAX_CYC) || stop_len > 4'(`PSQ_PW_MAX_CYC))
        width_err <= 1'b1;
      else if (restart_req)
        width_err <= 1'b0;
    end
  end

  // ==========================================================
  // Fault decode
  assign shut_req = overvoltage_sense_i | delayed_fault_input_i;
  assign fault_restart = shut_req | undervoltage_sense_i | cs_high_i
                       | restart_req | ~enable;

  // ==========================================================
  // Sequencer
  assign drive_en = (state == ST_RAMP) || (state == ST_RUN);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_HOLD:
      begin
        // Leave hold for ramp only once the node is discharged; shutdown leaves at once
        if (shut_latch || shut_req)
          next_state = ST_SHUT;
        else if (ss_level <= `PSQ_SS_LOW && !fault_restart)
          next_state = ST_RAMP;
      end
      ST_RAMP:
      begin
        if (shut_req)
          next_state = ST_SHUT;
        else if (fault_restart)
          next_state = ST_HOLD;
        else if (ss_level == `PSQ_SS_FULL)
          next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (shut_req)
          next_state = ST_SHUT;
        else if (fault_restart)
          next_state = ST_HOLD;
      end
      ST_SHUT:
        next_state = ST_SHUT;
      default:
        next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      state <= ST_HOLD;
    else if (ce_i)
      state <= next_state;
  end

  // Only power cycling clears this
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      shut_latch <= 1'b0;
    else if (ce_i && shut_req)
      shut_latch <= 1'b1;
  end

  // ==========================================================
  // Soft-start node model
  // Discharge is slower than charge, as the sink is weaker
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      ss_level <= 8'h00;
      ss_tick <= 8'h00;
    end
    else if (ce_i)
    begin
      if (drive_en)
      begin
        if (ss_tick >= `PSQ_SS_CHARGE_DIV - 8'h01)
        begin
          ss_tick <= 8'h00;
          if (ss_level != `PSQ_SS_FULL)
            ss_level <= ss_level + 8'h01;
        end
        else
          ss_tick <= ss_tick + 8'h01;
      end
      else if (undervoltage_sense_i)
      begin
        ss_tick <= 8'h00;
        ss_level <= 8'h00;
      end
      else if (ss_tick >= `PSQ_SS_DISCHARGE_DIV - 8'h01)
      begin
        ss_tick <= 8'h00;
        if (ss_level != 8'h00)
          ss_level <= ss_level - 8'h01;
      end
      else
        ss_tick <= ss_tick + 8'h01;
    end
  end

  // ==========================================================
  // Drive latch
  assign cap = max_on(period);
  assign limit = (state == ST_RUN) ? cap : duty_limit(cap, ss_level);
  assign duty_end = (phase >= limit);

  assign drive_clr = cs_low_i | cs_high_i | voltsecond_sense_i
                   | overvoltage_sense_i | delayed_fault_input_i
                   | undervoltage_sense_i | ~drive_en
                   | duty_end | stop_edge;
  assign drive_set = drive_en & (sync ? start_edge : osc_start);

  always_comb
  begin
    next_drive = drive;
    if (drive_clr)
      next_drive = 1'b0;
    else if (drive_set)
      next_drive = 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      drive <= 1'b0;
    else if (ce_i)
      drive <= next_drive;
  end

  // ==========================================================
  // Synchronisation latch
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      sync <= 1'b0;
    else if (ce_i)
    begin
      if (fault_restart)
        sync <= 1'b0;
      else if (drive_en && stop_edge)
        sync <= 1'b1;
    end
  end

  // ==========================================================
  // Current-limit latch feeding the delayed fault node
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
      charge_latch <= 1'b0;
    else if (ce_i)
    begin
      if (osc_on_end)
        charge_latch <= 1'b0;
      else if (cs_low_i && !cs_high_i)
        charge_latch <= 1'b1;
    end
  end

  // ==========================================================
  // Pin outputs
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      drive_o <= 1'b0;
      voltsecond_clamp_o <= 1'b1;
      delayed_fault_charge_o <= 1'b0;
      soft_start_discharge_o <= 1'b1;
      sync_o <= 1'b0;
      shutdown_o <= 1'b0;
    end
    else if (ce_i)
    begin
      drive_o <= next_drive;
      voltsecond_clamp_o <= ~next_drive;
      delayed_fault_charge_o <= charge_latch;
      soft_start_discharge_o <= ~drive_en;
      sync_o <= sync;
      shutdown_o <= shut_latch;
    end
  end

  // ==========================================================
  // APB slave, no wait state: pready rises the cycle after setup
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign addr_ok = (paddr_i == `PSQ_CTRL_OFS) || (paddr_i == `PSQ_PERIOD_OFS)
                || (paddr_i == `PSQ_STATUS_OFS) || (paddr_i == `PSQ_LEVEL_OFS);

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (paddr_i)
      `PSQ_CTRL_OFS: rd_value[`PSQ_CTRL_ENABLE_BIT] = enable;
      `PSQ_PERIOD_OFS: rd_value[9:0] = period;
      `PSQ_STATUS_OFS:
      begin
        rd_value[`PSQ_ST_DRIVE_BIT] = drive;
        rd_value[`PSQ_ST_SYNC_BIT] = sync;
        rd_value[`PSQ_ST_SHUT_BIT] = shut_latch;
        rd_value[`PSQ_ST_CHARGE_BIT] = charge_latch;
        rd_value[`PSQ_ST_WIDTH_BIT] = width_err;
        rd_value[`PSQ_ST_STATE_LSB +: 4] = state;
      end
      `PSQ_LEVEL_OFS: rd_value[7:0] = ss_level;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup & ~addr_ok;
      prdata_o <= (apb_setup && !pwrite_i) ? rd_value : 32'h0000_0000;
    end
  end

  // Control writes; restart is a one-cycle request
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      enable <= `PSQ_ENABLE_RESET;
      period <= `PSQ_PERIOD_RESET;
      restart_req <= 1'b0;
    end
    else if (ce_i)
    begin
      restart_req <= 1'b0;
      if (apb_write && paddr_i == `PSQ_CTRL_OFS)
      begin
        enable <= pwdata_i[`PSQ_CTRL_ENABLE_BIT];
        restart_req <= pwdata_i[`PSQ_CTRL_RESTART_BIT];
      end
      if (apb_write && paddr_i == `PSQ_PERIOD_OFS && pwdata_i[9:0] > 10'h004)
        period <= pwdata_i[9:0];
    end
  end
endmodule : primary_side_pwm_sequencer

// ### testbench/psq_partner.sv
`timescale 1ns/10ps
module psq_partner
#(
  parameter int PER = 240,
  parameter int ON = 100
)
(
  input wire logic clock_i,
  input wire logic run_i,
  input wire logic wide_i,
  output logic start_o = 1'b0,
  output logic stop_o = 1'b0
);
  // ====
  // Secondary controller: start and stop edges
  // Stretched pulses only when the bench asks for a width fault
  int cnt = 0;
  int w;
  assign w = wide_i ? 9 : 2;
  always @(posedge clock_i)
  begin
    cnt <= (run_i && cnt < PER - 1) ? cnt + 1 : 0;
    start_o <= run_i && cnt < w;
    stop_o <= run_i && cnt >= ON && cnt < ON + w;
  end
endmodule : psq_partner

// ### testbench/psq_chk.sv
`timescale 1ns/10ps
module psq_chk
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic cs_low_i,
  input wire logic cs_high_i,
  input wire logic pulse_command_stop_i,
  input wire logic delayed_fault_input_i,
  input wire logic overvoltage_sense_i,
  input wire logic undervoltage_sense_i,
  input wire logic voltsecond_sense_i,
  input wire logic drive_o,
  input wire logic sync_o,
  input wire logic shutdown_o,
  input wire logic voltsecond_clamp_o,
  input wire logic delayed_fault_charge_o,
  input wire logic soft_start_discharge_o
);
  // ====
  // Helpers
  // Cap valid for the reset period only; one cycle of output lag
  localparam int CAP = 193;
  logic [9:0] on_len;
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i || !drive_o)
      on_len <= 10'h000;
    else if (ce_i && on_len != 10'h3FF)
      on_len <= on_len + 10'h001;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_limit;
    (ce_i && cs_low_i && !cs_high_i) [*2];
  endsequence
  sequence s_fault;
    ce_i && (cs_low_i || cs_high_i || voltsecond_sense_i || overvoltage_sense_i
      || delayed_fault_input_i || undervoltage_sense_i);
  endsequence
  // ====
  // Properties
  chk_clamp_drive:
    assert property (voltsecond_clamp_o == !drive_o) else $error("clamp mismatch");
  chk_shut_low:
    assert property (shutdown_o |-> !drive_o) else $error("drive in shutdown");
  chk_fault_clear:
    assert property (s_fault |=> !drive_o) else $error("fault left drive on");
  chk_df_latch:
    assert property (ce_i && delayed_fault_input_i |-> ##[1:2] shutdown_o)
      else $error("no shutdown on delayed fault");
  chk_ov_latch:
    assert property (ce_i && overvoltage_sense_i |-> ##[1:2] shutdown_o)
      else $error("no shutdown on overvoltage");
  chk_shut_stays:
    assert property (shutdown_o |=> shutdown_o) else $error("shutdown released");
  chk_limit_charge:
    assert property (s_limit |-> ##[1:3] delayed_fault_charge_o) else $error("no charge");
  chk_uv_hold:
    assert property (ce_i && undervoltage_sense_i |-> ##[1:2] soft_start_discharge_o)
      else $error("no soft-start hold");
  chk_sync_clear:
    assert property (ce_i && (undervoltage_sense_i || cs_high_i) |-> ##[1:3] !sync_o)
      else $error("sync kept after fault");
  chk_stop_off:
    assert property (ce_i && $rose(pulse_command_stop_i) |=> !drive_o)
      else $error("stop ignored");
  chk_hold_low:
    assert property (soft_start_discharge_o [*2] |-> !drive_o) else $error("drive in hold");
  chk_duty_cap:
    assert property (on_len <= CAP) else $error("on-time above cap");
endmodule : psq_chk

bind primary_side_pwm_sequencer psq_chk chk_u (.*);

// ### testbench/primary_side_pwm_sequencer_tb.sv
`timescale 1ns/10ps
module primary_side_pwm_sequencer_tb
  import psq_pkg::*;
;
  `include "psq_map.svh"
  logic clock_i, resetn, ce, psel, penable, pwrite, cs_low, cs_high, uv, ov, df, vs, run, wide;
  logic pready, pslverr, e, start, stop, drive, sync, shut, charge, dis;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int errors = 0;
  int n_checks = 0;
  int hi;

  primary_side_pwm_sequencer dut_u (.clock_i(clock_i), .resetn_i(resetn), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cs_low_i(cs_low), .cs_high_i(cs_high), .pulse_command_start_i(start),
    .pulse_command_stop_i(stop), .delayed_fault_input_i(df), .overvoltage_sense_i(ov),
    .undervoltage_sense_i(uv), .voltsecond_sense_i(vs), .drive_o(drive), .sync_o(sync),
    .shutdown_o(shut), .voltsecond_clamp_o(), .delayed_fault_charge_o(charge),
    .soft_start_discharge_o(dis));
  psq_partner sec_u (.clock_i(clock_i), .run_i(run), .wide_i(wide), .start_o(start),
    .stop_o(stop));

  initial
  begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // ====
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
    begin
      cyc(1);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `PSQ_STATUS_OFS, 32'h0);
      n++;
    end
    while (r[b] !== 1'b1 && n < 9000);
    chk(32'(r[b]), 32'h1);
  endtask : wait_bit

  task automatic meas(input int n);
    hi = 0;
    repeat (n)
    begin
      cyc(1);
      if (drive === 1'b1)
        hi++;
    end
  endtask : meas

  task automatic end_sim;
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ====
  // Tests
  initial
  begin
    {resetn, psel, penable, pwrite, cs_low, cs_high, uv, ov, df, vs, run, wide} = 12'h000;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc(2);
    chk(drive, 1'b0);
    resetn <= 1'b1;
    apb(1'b0, `PSQ_CTRL_OFS, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, `PSQ_PERIOD_OFS, 32'h4);
    apb(1'b0, `PSQ_PERIOD_OFS, 32'h0);
    chk(r, 32'h10B);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    meas(1000);
    chk(32'(hi <= 8), 32'h1);
    wait_bit(10);
    meas(534);
    chk(32'(hi >= 360 && hi <= 386), 32'h1);
    // Clock enable low must freeze the drive at whatever level it has
    ce <= 1'b0;
    meas(300);
    chk(32'(hi == 0 || hi == 300), 32'h1);
    ce <= 1'b1;
    run <= 1'b1;
    wait_bit(1);
    // Four secondary periods, so at least one start lands below the cap
    meas(960);
    chk(32'(hi > 0 && hi <= 410), 32'h1);
    wide <= 1'b1;
    cyc(240);
    wide <= 1'b0;
    apb(1'b0, `PSQ_STATUS_OFS, 32'h0);
    chk(32'(r[4]), 32'h1);
    for (int j = 0; j < 2; j++)
    begin
      for (int n = 0; n < 1000 && drive !== 1'b1; n++)
        cyc(1);
      chk(drive, 1'b1);
      cs_low <= (j == 0);
      vs <= (j == 1);
      cyc(3);
      chk(drive, 1'b0);
      // The on-end clear may drop the latch for one cycle; look twice
      hi = charge;
      cyc(1);
      chk(32'(hi) | charge | (j == 1), 32'h1);
      chk(sync, 1'b1);
      cs_low <= 1'b0;
      vs <= 1'b0;
    end
    // Faults: undervoltage, high current, restart, disable
    for (int i = 0; i < 4; i++)
    begin
      run <= 1'b0;
      uv <= (i == 0);
      cs_high <= (i == 1);
      if (i >= 2)
        apb(1'b1, `PSQ_CTRL_OFS, (i == 2) ? 32'h3 : 32'h0);
      cyc(4);
      chk(sync, 1'b0);
      chk(drive, 1'b0);
      chk(dis | (i == 2), 1'b1);
      uv <= 1'b0;
      cs_high <= 1'b0;
      if (i == 3)
        apb(1'b1, `PSQ_CTRL_OFS, 32'h1);
      run <= 1'b1;
      wait_bit(1);
    end
    apb(1'b0, `PSQ_STATUS_OFS, 32'h0);
    chk(32'(r[4]), 32'h0);
    df <= 1'b1;
    cyc(4);
    chk(shut, 1'b1);
    df <= 1'b0;
    meas(300);
    chk(32'(hi), 32'h0);
    apb(1'b0, `PSQ_STATUS_OFS, 32'h0);
    chk(32'(r[11:8]), 32'(ST_SHUT));
    run <= 1'b0;
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(2);
    chk(shut, 1'b0);
    ov <= 1'b1;
    cyc(4);
    chk(shut, 1'b1);
    ov <= 1'b0;
    end_sim;
  end

  initial
  begin
    repeat (40000) @(posedge clock_i);
    errors++;
    end_sim;
  end
endmodule : primary_side_pwm_sequencer_tb
